// [smc_sleep_ctrl.sv]
// How it works
// - sleep instruction sleeps only when the sleep-enable bit is already set
// - mode field bits 4:3: 00 idle, 01 ADC quiet, 10 power-down, 11 reserved
// - interrupt wake holds the core four cycles past start-up, then handler
// - sleeping never clears register file or SRAM; clocks are only gated
// - a reset during sleep wakes to the reset vector
// - idle stops CPU and flash clocks; I/O, ADC, oscillator keep running
// - idle wakes on any enabled interrupt
// - enabled ADC starts a conversion on entering idle or ADC quiet mode
// - ADC quiet mode stops I/O, CPU, flash clocks; ADC clock and oscillator run
// - ADC quiet wakes on ADC, resets, self_program, level, pin change, watchdog
// - power-down stops the oscillator and every generated clock
// - power-down wakes on resets, level, pin change, watchdog; never edge
// - comparator switched off in power-down unless it uses the reference
// - ADC stays enabled in sleep; re-enabling flags an extended conversion
// - watchdog and fuse-enabled brown-out detector stay active in sleep
// - input buffers off when I/O and ADC clocks stop; wake pins stay on
// - bit 2 of the control register reads zero
// - internal reference on only for brown-out, comparator or ADC
`timescale 1ns/1ps
module smc_sleep_ctrl
    import smc_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    output logic                     wb_ack_o,
    input  wire logic                sleep_instr_i,
    input  wire logic [SMC_WK_N-1:0] wake_req_i,
    input  wire logic                reset_req_i,
    input  wire logic                bod_fuse_i,
    output logic                     cpu_clk_en_o,
    output logic                     flash_clk_en_o,
    output logic                     io_clk_en_o,
    output logic                     adc_clk_en_o,
    output logic                     osc_en_o,
    output logic                     core_halt_o,
    output logic                     irq_go_o,
    output logic                     reset_vec_o,
    output logic                     adc_start_o,
    output logic                     adc_ext_o,
    output logic                     cmp_off_o,
    output logic                     vref_en_o,
    output logic                     din_en_o,
    output logic                     wake_din_en_o,
    output logic                     sleep_o
);

    // {cpu, flash, io, adc, osc} enables for a mode
    function automatic logic [4:0] clk_mask(input smc_mode_t m, input logic asleep);
        logic [4:0] r;
        r = 5'h1F;
        if (asleep) begin
            unique case (m)
                SMC_IDLE:  r = 5'b00111;
                SMC_ADCNR: r = 5'b00011;
                SMC_PDOWN: r = 5'b00000;
                SMC_RSVD:  r = 5'h1F;
            endcase
        end
        return r;
    endfunction : clk_mask

    // interrupt lines allowed to end a given mode
    function automatic logic wake_ok(input smc_mode_t m, input logic [SMC_WK_N-1:0] s);
        logic [SMC_WK_N-1:0] allow;
        allow = '0;
        unique case (m)
            SMC_IDLE:  allow = '1;
            SMC_ADCNR: allow = 7'h5D;
            SMC_PDOWN: allow = 7'h45;
            SMC_RSVD:  allow = '0;
        endcase
        return |(s & allow);
    endfunction : wake_ok

    // two-flop synchronisers for pins
    logic [SMC_WK_N+1:0] sy1_r;
    logic [SMC_WK_N+1:0] sy2_r;
    logic [SMC_WK_N-1:0] wake_s;
    logic                rst_s;
    logic                bod_s;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sy1_r <= '0;
            sy2_r <= '0;
        end else begin
            sy1_r <= {bod_fuse_i, reset_req_i, wake_req_i};
            sy2_r <= sy1_r;
        end
    end

    assign wake_s = sy2_r[SMC_WK_N-1:0];
    assign rst_s  = sy2_r[SMC_WK_N];
    assign bod_s  = sy2_r[SMC_WK_N+1];

    smc_state_t           st_r,      st_nxt;
    smc_mode_t            mode_r,    mode_nxt;
    logic [SMC_CNT_W-1:0] cnt_r,     cnt_nxt;
    logic [7:0]           ctrl_r,    ctrl_nxt;
    logic [2:0]           cfg_r,     cfg_nxt;
    logic                 by_rst_r,  by_rst_nxt;
    logic                 ext_r,     ext_nxt;
    logic [4:0]           en_r,      en_nxt;
    logic                 halt_r,    halt_nxt;
    logic                 go_r,      go_nxt;
    logic                 rvec_r,    rvec_nxt;
    logic                 astart_r,  astart_nxt;
    logic                 cmp_r,     cmp_nxt;
    logic                 vref_r,    vref_nxt;
    logic                 din_r,     din_nxt;
    logic                 ack_r,     ack_nxt;
    logic [31:0]          dat_r,     dat_nxt;
    logic                 sleep_r,   sleep_nxt;
    smc_mode_t            req_mode;
    logic                 wb_req;
    logic                 asleep;

    assign req_mode = smc_mode_t'(ctrl_r[SMC_MODE_HI:SMC_MODE_LO]);
    assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_r;

    always_comb begin
        st_nxt     = st_r;
        mode_nxt   = mode_r;
        cnt_nxt    = cnt_r;
        ctrl_nxt   = ctrl_r;
        cfg_nxt    = cfg_r;
        by_rst_nxt = by_rst_r;
        ext_nxt    = ext_r;
        go_nxt     = 1'b0;
        rvec_nxt   = 1'b0;
        astart_nxt = 1'b0;
        dat_nxt    = dat_r;
        ack_nxt    = wb_req;
        if (wb_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == SMC_CTRL_ADR) begin
                ctrl_nxt = {wb_dat_i[7:3], 1'b0, wb_dat_i[1:0]};
            end else if (wb_adr_i == SMC_CFG_ADR) begin
                cfg_nxt = wb_dat_i[2:0];
            end
        end
        if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                SMC_CTRL_ADR: dat_nxt = {24'h0, ctrl_r};
                SMC_STAT_ADR: dat_nxt = {26'h0, by_rst_r, ext_r, mode_r, st_r};
                SMC_CFG_ADR:  dat_nxt = {29'h0, cfg_r};
                default:      dat_nxt = 32'h0;
            endcase
        end
        unique case (st_r)
            SMC_ST_RUN: begin
                if (sleep_instr_i && ctrl_r[SMC_SE_BIT] && req_mode != SMC_RSVD) begin
                    st_nxt   = SMC_ST_SLEEP;
                    mode_nxt = req_mode;
                    astart_nxt = cfg_r[SMC_ADC_EN_BIT] && req_mode != SMC_PDOWN;
                end
            end
            SMC_ST_SLEEP: begin
                if (rst_s) begin
                    st_nxt     = SMC_ST_WAKE;
                    by_rst_nxt = 1'b1;
                    cnt_nxt    = SMC_CNT_W'(SMC_HOLD_CYC - 1);
                end else if (wake_ok(mode_r, wake_s)) begin
                    st_nxt     = SMC_ST_WAKE;
                    by_rst_nxt = 1'b0;
                    cnt_nxt = (mode_r == SMC_PDOWN)
                        ? SMC_CNT_W'(SMC_STARTUP_CYC + SMC_HOLD_CYC - 1)
                        : SMC_CNT_W'(SMC_HOLD_CYC - 1);
                end
            end
            SMC_ST_WAKE: begin
                if (cnt_r == '0) begin
                    st_nxt   = SMC_ST_RUN;
                    go_nxt   = ~by_rst_r;
                    rvec_nxt = by_rst_r;
                    if (by_rst_r) begin
                        ctrl_nxt = SMC_CTRL_RST;
                        cfg_nxt  = SMC_CFG_RST;
                    end
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: st_nxt = SMC_ST_RUN;
        endcase
        // extended conversion after re-enable, set wins
        if (cfg_nxt[SMC_ADC_EN_BIT] && !cfg_r[SMC_ADC_EN_BIT]) begin
            ext_nxt = 1'b1;
        end else if (astart_nxt) begin
            ext_nxt = 1'b0;
        end
    end

    // core and memories only lose clocks, never state
    // watchdog and brown-out have own supply paths, never gated here
    assign asleep   = (st_nxt == SMC_ST_SLEEP);
    assign en_nxt   = clk_mask(mode_nxt, asleep);
    assign halt_nxt = (st_nxt != SMC_ST_RUN);
    assign cmp_nxt = cfg_nxt[SMC_ACD_BIT]
                   | (asleep && mode_nxt == SMC_PDOWN && !cfg_nxt[SMC_ACBG_BIT]);
    assign vref_nxt = bod_s
                    | (cfg_nxt[SMC_ACBG_BIT] & ~cfg_nxt[SMC_ACD_BIT])
                    | cfg_nxt[SMC_ADC_EN_BIT];
    // buffers off with io and adc clocks
    assign din_nxt = en_nxt[2] | en_nxt[1];
    assign sleep_nxt = asleep;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_r     <= SMC_ST_RUN;
            mode_r   <= SMC_IDLE;
            cnt_r    <= '0;
            ctrl_r   <= SMC_CTRL_RST;
            cfg_r    <= SMC_CFG_RST;
            by_rst_r <= 1'b0;
            ext_r    <= 1'b0;
            en_r     <= 5'h1F;
            halt_r   <= 1'b0;
            go_r     <= 1'b0;
            rvec_r   <= 1'b0;
            astart_r <= 1'b0;
            cmp_r    <= 1'b0;
            vref_r   <= 1'b0;
            din_r    <= 1'b1;
            ack_r    <= 1'b0;
            dat_r    <= 32'h0;
            sleep_r  <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            mode_r   <= mode_nxt;
            cnt_r    <= cnt_nxt;
            ctrl_r   <= ctrl_nxt;
            cfg_r    <= cfg_nxt;
            by_rst_r <= by_rst_nxt;
            ext_r    <= ext_nxt;
            en_r     <= en_nxt;
            halt_r   <= halt_nxt;
            go_r     <= go_nxt;
            rvec_r   <= rvec_nxt;
            astart_r <= astart_nxt;
            cmp_r    <= cmp_nxt;
            vref_r   <= vref_nxt;
            din_r    <= din_nxt;
            ack_r    <= ack_nxt;
            dat_r    <= dat_nxt;
            sleep_r  <= sleep_nxt;
        end
    end

    assign wb_dat_o       = dat_r;
    assign wb_ack_o       = ack_r;
    assign cpu_clk_en_o   = en_r[4];
    assign flash_clk_en_o = en_r[3];
    assign io_clk_en_o    = en_r[2];
    assign adc_clk_en_o   = en_r[1];
    assign osc_en_o       = en_r[0];
    assign core_halt_o    = halt_r;
    assign irq_go_o       = go_r;
    assign reset_vec_o    = rvec_r;
    assign adc_start_o    = astart_r;
    assign adc_ext_o      = ext_r;
    assign cmp_off_o      = cmp_r;
    assign vref_en_o      = vref_r;
    assign din_en_o       = din_r;
    assign wake_din_en_o  = 1'b1;
    assign sleep_o        = sleep_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sleep_needs_se_a: assert property (
        $rose(sleep_o) |-> $past(ctrl_r[SMC_SE_BIT] && sleep_instr_i))
        else $error("sleep entered without sleep enable");

    nop_sleep_a: assert property (
        st_r == SMC_ST_RUN && sleep_instr_i && !ctrl_r[SMC_SE_BIT]
        |=> !sleep_o && cpu_clk_en_o)
        else $error("sleep taken with enable clear");

    idle_clocks_a: assert property (
        sleep_o && mode_r == SMC_IDLE |-> !cpu_clk_en_o && !flash_clk_en_o
        && io_clk_en_o && adc_clk_en_o && osc_en_o)
        else $error("idle clock gating wrong");

    adcnr_clocks_a: assert property (
        sleep_o && mode_r == SMC_ADCNR |-> !io_clk_en_o && !cpu_clk_en_o
        && adc_clk_en_o && osc_en_o)
        else $error("adc quiet clock gating wrong");

    pdown_clocks_a: assert property (
        sleep_o && mode_r == SMC_PDOWN |-> !osc_en_o && !adc_clk_en_o
        && !io_clk_en_o && !din_en_o)
        else $error("power-down clock gating wrong");

    wake_hold_a: assert property (
        $fell(sleep_o) && mode_r != SMC_PDOWN && !by_rst_r
        |-> core_halt_o [*4] ##1 (irq_go_o && !core_halt_o))
        else $error("wake hold not four cycles");

    edge_no_wake_a: assert property (
        sleep_o && mode_r == SMC_PDOWN && !rst_s
        && wake_s == (SMC_WK_N'(1) << SMC_WK_EDGE) |=> sleep_o)
        else $error("edge interrupt woke power-down");

    reset_wake_a: assert property (
        sleep_o && rst_s |-> ##[1:8] reset_vec_o)
        else $error("reset in sleep not taken to vector");

    adc_auto_a: assert property (
        $rose(sleep_o) && mode_r != SMC_PDOWN && cfg_r[SMC_ADC_EN_BIT] |-> adc_start_o)
        else $error("no conversion on sleep entry");

    rsvd_zero_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == SMC_CTRL_ADR |-> !wb_dat_o[SMC_RSVD_BIT])
        else $error("reserved bit read as one");

    cmp_pd_a: assert property (
        sleep_o && mode_r == SMC_PDOWN && !cfg_r[SMC_ACBG_BIT] |-> cmp_off_o)
        else $error("comparator not off in power-down");

    idle_wake_a: assert property (
        sleep_o && mode_r == SMC_IDLE && (|wake_s) |=> !sleep_o)
        else $error("idle ignored an enabled interrupt");

    adcnr_filter_a: assert property (
        sleep_o && mode_r == SMC_ADCNR && !rst_s && !wake_s[SMC_WK_LEVEL]
        && !wake_s[SMC_WK_PCINT] && !wake_s[SMC_WK_SPM] && !wake_s[SMC_WK_ADC]
        && !wake_s[SMC_WK_WDT] |=> sleep_o)
        else $error("adc quiet woken by a barred source");

    rsvd_mode_a: assert property (
        st_r == SMC_ST_RUN && sleep_instr_i && ctrl_r[SMC_MODE_HI:SMC_MODE_LO] == 2'h3
        |=> !sleep_o)
        else $error("reserved mode entered sleep");

    ext_set_a: assert property (
        $rose(cfg_r[SMC_ADC_EN_BIT]) |-> adc_ext_o)
        else $error("re-enable did not flag extended conversion");

    din_off_a: assert property (
        sleep_o && !io_clk_en_o && !adc_clk_en_o |-> !din_en_o && wake_din_en_o)
        else $error("input buffers not switched with clocks");

    vref_demand_a: assert property (
        vref_en_o |-> $past(bod_s) || cfg_r[SMC_ADC_EN_BIT] || cfg_r[SMC_ACBG_BIT])
        else $error("reference on without a user");

    cmp_off_why_a: assert property (
        cmp_off_o |-> cfg_r[SMC_ACD_BIT] || (sleep_o && mode_r == SMC_PDOWN))
        else $error("comparator off without cause");

    cover_idle_c:  cover property ($rose(sleep_o) && mode_r == SMC_IDLE);
    cover_pdwake_c: cover property (mode_r == SMC_PDOWN && $fell(sleep_o) && !by_rst_r);
    cover_rstvec_c: cover property (reset_vec_o);
    cover_nop_c: cover property (st_r == SMC_ST_RUN && sleep_instr_i && !ctrl_r[SMC_SE_BIT]);
    cover_adcnr_c: cover property ($rose(sleep_o) && mode_r == SMC_ADCNR && adc_start_o);

endmodule : smc_sleep_ctrl

// [smc_pkg.sv]
package smc_pkg;
    // register byte addresses
    localparam logic [3:0] SMC_CTRL_ADR = 4'h0;
    localparam logic [3:0] SMC_STAT_ADR = 4'h4;
    localparam logic [3:0] SMC_CFG_ADR  = 4'h8;
    // mcu_sleep_control fields
    localparam int SMC_SE_BIT   = 5;
    localparam int SMC_MODE_HI  = 4;
    localparam int SMC_MODE_LO  = 3;
    localparam int SMC_RSVD_BIT = 2;
    localparam logic [7:0] SMC_CTRL_RST = 8'h00;
    // configuration fields
    localparam int SMC_ADC_EN_BIT = 0;
    localparam int SMC_ACD_BIT    = 1;
    localparam int SMC_ACBG_BIT   = 2;
    localparam logic [2:0] SMC_CFG_RST = 3'h0;
    // wake request lines
    localparam int SMC_WK_LEVEL = 0;
    localparam int SMC_WK_EDGE  = 1;
    localparam int SMC_WK_PCINT = 2;
    localparam int SMC_WK_SPM   = 3;
    localparam int SMC_WK_ADC   = 4;
    localparam int SMC_WK_IO    = 5;
    localparam int SMC_WK_WDT   = 6;
    localparam int SMC_WK_N     = 7;
    // timing
    localparam int SMC_CLK_NS     = 5;
    localparam int SMC_STARTUP_NS = 1000;
    localparam int SMC_STARTUP_CYC = (SMC_STARTUP_NS + SMC_CLK_NS - 1) / SMC_CLK_NS;
    localparam int SMC_HOLD_CYC   = 4;
    localparam int SMC_CNT_W      = 9;

    typedef enum logic [1:0] {
        SMC_IDLE  = 2'b00,
        SMC_ADCNR = 2'b01,
        SMC_PDOWN = 2'b10,
        SMC_RSVD  = 2'b11
    } smc_mode_t;

    typedef enum logic [1:0] {
        SMC_ST_RUN   = 2'b00,
        SMC_ST_SLEEP = 2'b01,
        SMC_ST_WAKE  = 2'b10
    } smc_state_t;
endpackage : smc_pkg

// [smc_core_model.sv]
`timescale 1ns/1ps
module smc_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       go_i,
    input  wire logic       core_halt_i,
    input  wire logic       irq_go_i,
    input  wire logic       reset_vec_i,
    output logic            sleep_instr_o,
    output logic [7:0]      irq_cnt_o,
    output logic [7:0]      rst_cnt_o
);
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sleep_instr_o <= 1'b0;
            irq_cnt_o     <= 8'h00;
            rst_cnt_o     <= 8'h00;
        end else begin
            sleep_instr_o <= go_i & ~core_halt_i;
            irq_cnt_o     <= irq_cnt_o + {7'h00, irq_go_i};
            rst_cnt_o     <= rst_cnt_o + {7'h00, reset_vec_i};
        end
    end
endmodule : smc_core_model

// [tb.sv]
`timescale 1ns/1ps
module tb;
    import smc_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat;
    logic [SMC_WK_N-1:0] wake = '0;
    logic reset_req = 1'b0, bod = 1'b0, sinstr, ack, halt, irq, rvec, ast, aext;
    logic cmp_off, vref, din, wdin, sleep, cpu, fl, io, adc, osc;
    logic [7:0] irq_cnt, rst_cnt;
    logic [4:0] clks;
    int fails = 0, checks_done = 0;
    assign clks = {cpu, fl, io, adc, osc};
    always #2.5 clk_i = ~clk_i;
    smc_sleep_ctrl dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .sleep_instr_i(sinstr), .wake_req_i(wake), .reset_req_i(reset_req),
        .bod_fuse_i(bod), .cpu_clk_en_o(cpu), .flash_clk_en_o(fl), .io_clk_en_o(io),
        .adc_clk_en_o(adc), .osc_en_o(osc), .core_halt_o(halt), .irq_go_o(irq),
        .reset_vec_o(rvec), .adc_start_o(ast), .adc_ext_o(aext), .cmp_off_o(cmp_off),
        .vref_en_o(vref), .din_en_o(din), .wake_din_en_o(wdin), .sleep_o(sleep));
    smc_core_model core_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go), .core_halt_i(halt),
        .irq_go_i(irq), .reset_vec_i(rvec), .sleep_instr_o(sinstr), .irq_cnt_o(irq_cnt),
        .rst_cnt_o(rst_cnt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        // hold until ack is sampled high; data taken at that same edge
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic wait_sleep(input logic v);
        int n;
        n = 0;
        while (sleep !== v && n < 300) begin
            tick(1);
            n++;
        end
        chk(sleep, v);
    endtask : wait_sleep

    task automatic enter(input logic [7:0] c);
        logic [31:0] q;
        wb(1'b1, SMC_CTRL_ADR, {24'h0, c}, q);
        @(posedge clk_i);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
    endtask : enter

    task automatic wake_check(input int hold, input logic isr);
        int n;
        wait_sleep(1'b0);
        n = 1;
        @(posedge clk_i);
        wake      <= '0;
        reset_req <= 1'b0;
        #1;
        while (halt === 1'b1 && n < 400) begin
            n++;
            tick(1);
        end
        chk(32'(n), 32'(hold));
        chk({30'h0, irq, rvec}, {30'h0, isr, ~isr});
    endtask : wake_check

    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, SMC_CTRL_ADR, 32'h0, q);
        chk(q, {24'h0, SMC_CTRL_RST});
        wb(1'b1, SMC_CTRL_ADR, 32'h0000_003F, q);
        wb(1'b0, SMC_CTRL_ADR, 32'h0, q);
        chk(q, 32'h0000_003B);
        wb(1'b1, 4'hC, 32'h0000_00FF, q);
        wb(1'b0, 4'hC, 32'h0, q);
        chk(q, 32'h0000_0000);
        wb(1'b1, SMC_CFG_ADR, 32'h0000_0007, q);
        wb(1'b0, SMC_CFG_ADR, 32'h0, q);
        chk(q, 32'h0000_0007);
        wb(1'b0, SMC_STAT_ADR, 32'h0, q);
        chk(q, 32'h0000_0010);
        wb(1'b1, SMC_CFG_ADR, 32'h0, q);
    endtask : t_regs

    task automatic t_nosleep();
        logic [7:0] c[2] = '{8'h00, 8'h38};
        foreach (c[i]) begin
            enter(c[i]);
            tick(6);
            chk({31'h0, sleep}, 32'h0);
            chk({27'h0, clks}, 32'h0000_001F);
        end
    endtask : t_nosleep

    task automatic t_idle();
        logic [31:0] q;
        wb(1'b1, SMC_CFG_ADR, 32'h0000_0001, q);
        tick(1);
        chk({30'h0, aext, vref}, 32'h0000_0003);
        enter(8'h20);
        wait_sleep(1'b1);
        chk({26'h0, ast, clks}, 32'h0000_0027);
        @(posedge clk_i);
        wake[SMC_WK_IO] <= 1'b1;
        wake_check(SMC_HOLD_CYC, 1'b1);
        chk({31'h0, aext}, 32'h0);
    endtask : t_idle

    task automatic t_adcnr();
        enter(8'h28);
        wait_sleep(1'b1);
        chk({26'h0, ast, clks}, 32'h0000_0023);
        @(posedge clk_i);
        wake[SMC_WK_IO] <= 1'b1;
        tick(10);
        chk({31'h0, sleep}, 32'h1);
        @(posedge clk_i);
        wake[SMC_WK_ADC] <= 1'b1;
        wake_check(SMC_HOLD_CYC, 1'b1);
    endtask : t_adcnr

    task automatic t_pdown();
        logic [31:0] q;
        wb(1'b1, SMC_CFG_ADR, 32'h0, q);
        enter(8'h30);
        wait_sleep(1'b1);
        chk({23'h0, wdin, ast, din, cmp_off, clks}, 32'h0000_0120);
        @(posedge clk_i);
        wake[SMC_WK_EDGE] <= 1'b1;
        tick(10);
        chk({31'h0, sleep}, 32'h1);
        @(posedge clk_i);
        wake[SMC_WK_LEVEL] <= 1'b1;
        wake_check(SMC_STARTUP_CYC + SMC_HOLD_CYC, 1'b1);
    endtask : t_pdown

    task automatic t_reset();
        logic [31:0] q;
        enter(8'h20);
        wait_sleep(1'b1);
        @(posedge clk_i);
        reset_req <= 1'b1;
        wake_check(SMC_HOLD_CYC, 1'b0);
        wb(1'b0, SMC_CTRL_ADR, 32'h0, q);
        chk(q, {24'h0, SMC_CTRL_RST});
        wb(1'b0, SMC_STAT_ADR, 32'h0, q);
        chk(q, 32'h0000_0020);
    endtask : t_reset

    task automatic t_vref();
        tick(2);
        chk({31'h0, vref}, 32'h0);
        @(posedge clk_i);
        bod <= 1'b1;
        tick(6);
        chk({31'h0, vref}, 32'h1);
    endtask : t_vref

    task automatic final_report();
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_nosleep();
        t_idle();
        t_adcnr();
        t_pdown();
        t_reset();
        t_vref();
        chk({24'h0, irq_cnt}, 32'h3);
        chk({24'h0, rst_cnt}, 32'h1);
        final_report();
    end

    initial begin
        #50000;
        fails++;
        final_report();
    end
endmodule : tb
